// ===== rhb_pkg.sv
// Shared constants for the ring heartbeat supervisor and field node
package rhb_pkg;
  localparam longint CLK_HZ = 100_000_000;
  // One second time stamp interval
  localparam longint SEC_S = 1;
  localparam longint SEC_CYC = SEC_S * CLK_HZ;
  // Loop fault isolation timeout, two hours
  localparam longint ISO_TMO_H = 2;
  localparam longint ISO_TMO_CYC = ISO_TMO_H * 3600 * CLK_HZ;
  // Chosen cycle counts with no documented figure
  localparam int HB_PERIOD_CYC = 1000;
  localparam int LOSS_CYC = 4000;
  localparam int DWELL_CYC = 3000;
  localparam int OFFLINE_CYC = 4000;
  localparam int STAT_CYC = 500;
  localparam int DEV_AW = 8;
  localparam int TIME_W = 32;
  // APB register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DEVCFG = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_OFFLINE = 8'h0c;
  localparam int CTRL_RST_BIT = 0;
  localparam int FLAGS_ALARM_POS = 16;
  localparam logic [31:0] DEVCFG_RST = 32'h0000_00ff;
endpackage

// ===== rhb_loop_if.sv
// Ring loop carrier between supervisor and one field node
`timescale 1ns/1ns
interface rhb_loop_if;
  // Heartbeat out of supervisor ports A and B
  logic hb_a;
  logic hb_b;
  logic hb_ts;
  logic [31:0] hb_time;
  // Heartbeat returning to supervisor ports, driven by the ring model
  logic rx_a;
  logic rx_b;
  // Heartbeat arriving at node ports, driven by the ring model
  logic dev_hb_a;
  logic dev_hb_b;
  // Node isolation relays, high means open
  logic relay_a_open;
  logic relay_b_open;
  // Node status report
  logic st_vld;
  logic [7:0] st_addr;
  logic st_fault;
  logic st_alarm;
  modport ctl (output hb_a, hb_b, hb_ts, hb_time, input rx_a, rx_b, st_vld, st_addr, st_fault, st_alarm);
  modport dev (input dev_hb_a, dev_hb_b, hb_ts, hb_time,
               output relay_a_open, relay_b_open, st_vld, st_addr, st_fault, st_alarm);
endinterface

// ===== rhb_ctl.sv
// Ring supervisor: heartbeat, continuity check, latched faults, APB registers
`timescale 1ns/1ns
module rhb_ctl #(
  parameter int ND = 8,
  parameter int NF = 4,
  parameter int NA = 4,
  parameter longint SEC_CYC = rhb_pkg::SEC_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  rhb_loop_if.ctl lp,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NF-1:0] fault_in,
  input wire logic [NA-1:0] alarm_in,
  input wire logic reset_btn,
  input wire logic [31:0] rtc_time,
  output logic [NF+1:0] fault_r,
  output logic [NA:0] alarm_r,
  output logic [ND-1:0] offline_r,
  output logic trouble,
  output logic reset_done_r
);
  logic [15:0] hb_cnt_r;
  logic [39:0] sec_cnt_r;
  logic ts_pend_r;
  logic hb_a_r;
  logic hb_ts_r;
  logic [31:0] hb_time_r;
  logic sent_r;
  logic ret_a_r;
  logic ret_b_r;
  logic loop_bad_r;
  logic [ND-1:0] dev_fault_r;
  logic [ND-1:0] dev_alarm_r;
  logic [ND-1:0] off_now;
  logic [31:0] devcfg_r;
  logic [31:0] prdata_r;
  wire hb_tick = hb_cnt_r == 16'(rhb_pkg::HB_PERIOD_CYC - 1);
  wire sec_tick = sec_cnt_r == 40'(SEC_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Heartbeat out of both ports, time stamp on the beat at or after each second tick, and on the next one too if they coincide
  assign lp.hb_a = hb_a_r;
  assign lp.hb_b = hb_a_r;
  assign lp.hb_ts = hb_ts_r;
  assign lp.hb_time = hb_time_r;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hb_cnt_r <= 16'h0000;
      sec_cnt_r <= 40'h00_0000_0000;
      ts_pend_r <= 1'b0;
      hb_a_r <= 1'b0;
      hb_ts_r <= 1'b0;
      hb_time_r <= 32'h0000_0000;
    end
    else
    begin
      hb_cnt_r <= hb_tick ? 16'h0000 : hb_cnt_r + 16'h0001;
      sec_cnt_r <= sec_tick ? 40'h00_0000_0000 : sec_cnt_r + 40'h00_0000_0001;
      ts_pend_r <= sec_tick | (ts_pend_r & ~hb_tick);
      hb_a_r <= hb_tick;
      hb_ts_r <= hb_tick & (ts_pend_r | sec_tick);
      if (hb_tick & (ts_pend_r | sec_tick))
        hb_time_r <= rtc_time;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Continuity: each beat must come back on the opposite port
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sent_r <= 1'b0;
      ret_a_r <= 1'b0;
      ret_b_r <= 1'b0;
      loop_bad_r <= 1'b0;
    end
    else
    begin
      sent_r <= sent_r | hb_tick;
      ret_a_r <= lp.rx_a | (ret_a_r & ~hb_tick);
      ret_b_r <= lp.rx_b | (ret_b_r & ~hb_tick);
      if (hb_tick & sent_r)
        loop_bad_r <= ~(ret_a_r & ret_b_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per node silence timer and last reported status
  genvar gi;
  generate
    for (gi = 0; gi < ND; gi++)
    begin : g_node
      logic [15:0] sil_r;
      logic flt_r;
      logic alm_r;
      wire hit = lp.st_vld & (lp.st_addr == 8'(gi));
      assign off_now[gi] = devcfg_r[gi] & (sil_r == 16'(rhb_pkg::OFFLINE_CYC));
      // One process per node for its timer and both flags, gathered into the vectors
      assign dev_fault_r[gi] = flt_r;
      assign dev_alarm_r[gi] = alm_r;
      always_ff @(posedge clock or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          sil_r <= 16'h0000;
          flt_r <= 1'b0;
          alm_r <= 1'b0;
        end
        else if (hit)
        begin
          sil_r <= 16'h0000;
          flt_r <= lp.st_fault;
          alm_r <= lp.st_alarm;
        end
        else if (sil_r != 16'(rhb_pkg::OFFLINE_CYC))
          sil_r <= sil_r + 16'h0001;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Latching and reset acceptance
  wire [NF+1:0] fault_now = {fault_in, |dev_fault_r, loop_bad_r};
  wire [NA:0] alarm_now = {alarm_in, |dev_alarm_r};
  wire apb_wr = psel & penable & pwrite;
  wire rst_req = reset_btn | (apb_wr & (paddr == rhb_pkg::REG_CTRL) & pwdata[rhb_pkg::CTRL_RST_BIT]);
  wire cond_any = |fault_now | |alarm_now | |off_now;
  wire accept = rst_req & ~cond_any;
  assign trouble = |fault_r | |offline_r;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fault_r <= '0;
      alarm_r <= '0;
      offline_r <= '0;
      reset_done_r <= 1'b0;
    end
    else
    begin
      // Set wins over clear; a reset is refused while any fault, alarm or offline condition is active
      fault_r <= (accept ? '0 : fault_r) | fault_now;
      alarm_r <= (accept ? '0 : alarm_r) | alarm_now;
      offline_r <= (accept ? '0 : offline_r) | off_now;
      reset_done_r <= accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  wire sel_ctrl = paddr == rhb_pkg::REG_CTRL;
  wire sel_cfg = paddr == rhb_pkg::REG_DEVCFG;
  wire sel_flags = paddr == rhb_pkg::REG_FLAGS;
  wire sel_off = paddr == rhb_pkg::REG_OFFLINE;
  wire mapped = sel_ctrl | sel_cfg | sel_flags | sel_off;
  wire [31:0] flags_word = (32'(alarm_r) << rhb_pkg::FLAGS_ALARM_POS) | 32'(fault_r);
  wire [31:0] rd_mux = sel_cfg ? devcfg_r : sel_flags ? flags_word : sel_off ? 32'(offline_r) : 32'h0000_0000;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      devcfg_r <= rhb_pkg::DEVCFG_RST;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      if (psel & ~penable)
        prdata_r <= rd_mux;
      if (apb_wr & sel_cfg)
        devcfg_r <= pwdata;
    end
  end
endmodule

// ===== rhb_dev.sv
// Ring field node: isolation relays, heartbeat search, status reports
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
module rhb_dev #(
  parameter logic [7:0] ADDR = 8'h00,
  parameter int LOSS_CYC = rhb_pkg::LOSS_CYC,
  parameter int DWELL_CYC = rhb_pkg::DWELL_CYC,
  parameter int STAT_CYC = rhb_pkg::STAT_CYC,
  parameter longint TMO_CYC = rhb_pkg::ISO_TMO_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  rhb_loop_if.dev lp,
  input wire logic local_fault,
  input wire logic local_alarm,
  output logic local_out_r,
  output logic iso_active,
  output logic iso_disabled,
  output logic hb_ok_r,
  output logic [31:0] time_r,
  output logic time_stamp_r
);
  typedef enum logic [4:0] {
    RHB_IDLE = 5'h01,
    RHB_OPEN_A = 5'h02,
    RHB_OPEN_B = 5'h04,
    RHB_HOLD = 5'h08,
    RHB_OFF = 5'h10
  } rhb_state_e;

  rhb_state_e state_r;
  rhb_state_e state_nxt;
  logic relay_a_r;
  logic relay_b_r;
  logic relay_a_nxt;
  logic relay_b_nxt;
  logic [15:0] loss_cnt_r;
  logic [15:0] dwell_cnt_r;
  logic [39:0] tmo_cnt_r;
  logic [15:0] stat_cnt_r;
  logic st_vld_r;
  logic st_fault_r;
  logic st_alarm_r;

  ////////////////////////////////////////////////////////////////////////
  // Heartbeat is heard only through a closed relay
  wire hb_port_a = lp.dev_hb_a & ~relay_a_r;
  wire hb_port_b = lp.dev_hb_b & ~relay_b_r;
  wire hb_seen = hb_port_a | hb_port_b;
  wire loss_hit = ~hb_seen & (loss_cnt_r == 16'(LOSS_CYC - 1));
  wire dwell_hit = dwell_cnt_r == 16'(DWELL_CYC - 1);
  wire tmo_hit = tmo_cnt_r == 40'(TMO_CYC - 1);
  wire searching = (state_r == RHB_OPEN_A) | (state_r == RHB_OPEN_B);

  assign lp.relay_a_open = relay_a_r;
  assign lp.relay_b_open = relay_b_r;
  assign iso_active = searching;
  assign iso_disabled = state_r == RHB_OFF;

  ////////////////////////////////////////////////////////////////////////
  // Isolation routine next state and relay positions
  always_comb
  begin
    state_nxt = state_r;
    relay_a_nxt = relay_a_r;
    relay_b_nxt = relay_b_r;
    case (state_r)
      RHB_IDLE:
      begin
        if (loss_hit)
        begin
          state_nxt = RHB_OPEN_A;
          relay_a_nxt = 1'b1;
          relay_b_nxt = 1'b0;
        end
      end
      RHB_OPEN_A:
      begin
        if (hb_port_b)
          state_nxt = RHB_HOLD;
        else if (tmo_hit)
        begin
          state_nxt = RHB_OFF;
          relay_a_nxt = 1'b0;
          relay_b_nxt = 1'b0;
        end
        else if (dwell_hit)
        begin
          state_nxt = RHB_OPEN_B;
          relay_a_nxt = 1'b0;
          relay_b_nxt = 1'b1;
        end
      end
      RHB_OPEN_B:
      begin
        if (hb_port_a)
          state_nxt = RHB_HOLD;
        else if (tmo_hit)
        begin
          state_nxt = RHB_OFF;
          relay_a_nxt = 1'b0;
          relay_b_nxt = 1'b0;
        end
        else if (dwell_hit)
        begin
          state_nxt = RHB_OPEN_A;
          relay_a_nxt = 1'b1;
          relay_b_nxt = 1'b0;
        end
      end
      RHB_HOLD:
      begin
        // Faulted side stays open while the beat keeps coming
        if (loss_hit)
        begin
          state_nxt = RHB_OPEN_A;
          relay_a_nxt = 1'b1;
          relay_b_nxt = 1'b0;
        end
      end
      RHB_OFF:
      begin
        if (hb_seen)
          state_nxt = RHB_IDLE;
      end
      default:
      begin
        state_nxt = RHB_IDLE;
        relay_a_nxt = 1'b0;
        relay_b_nxt = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State and relay registers
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= RHB_IDLE;
      relay_a_r <= 1'b0;
      relay_b_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      relay_a_r <= relay_a_nxt;
      relay_b_r <= relay_b_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Loss, dwell and timeout counters
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loss_cnt_r <= 16'h0000;
      dwell_cnt_r <= 16'h0000;
      tmo_cnt_r <= 40'h00_0000_0000;
    end
    else
    begin
      // Silence timer runs only while listening in idle or hold
      if (hb_seen | searching | (state_r == RHB_OFF) | loss_hit)
        loss_cnt_r <= 16'h0000;
      else
        loss_cnt_r <= loss_cnt_r + 16'h0001;
      // Dwell restarts on every side change
      if (~searching | (state_nxt != state_r))
        dwell_cnt_r <= 16'h0000;
      else
        dwell_cnt_r <= dwell_cnt_r + 16'h0001;
      // Timeout counts from the start of the routine
      if (~searching)
        tmo_cnt_r <= 40'h00_0000_0000;
      else
        tmo_cnt_r <= tmo_cnt_r + 40'h00_0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Periodic status report, independent of heartbeat state
  assign lp.st_vld = st_vld_r;
  assign lp.st_addr = ADDR;
  assign lp.st_fault = st_fault_r;
  assign lp.st_alarm = st_alarm_r;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stat_cnt_r <= 16'h0000;
      st_vld_r <= 1'b0;
      st_fault_r <= 1'b0;
      st_alarm_r <= 1'b0;
    end
    else
    begin
      stat_cnt_r <= (stat_cnt_r == 16'(STAT_CYC - 1)) ? 16'h0000 : stat_cnt_r + 16'h0001;
      st_vld_r <= stat_cnt_r == 16'(STAT_CYC - 1);
      if (stat_cnt_r == 16'(STAT_CYC - 1))
      begin
        st_fault_r <= local_fault;
        st_alarm_r <= local_alarm;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Local function carries on when cut off; the time word holds the last stamp heard
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      local_out_r <= 1'b0;
      hb_ok_r <= 1'b0;
      time_r <= 32'h0000_0000;
      time_stamp_r <= 1'b0;
    end
    else
    begin
      local_out_r <= local_fault | local_alarm;
      hb_ok_r <= (state_r == RHB_IDLE) | (state_r == RHB_HOLD);
      time_stamp_r <= hb_seen & lp.hb_ts;
      if (hb_seen & lp.hb_ts)
        time_r <= lp.hb_time;
    end
  end
endmodule

// ===== rhb_assertions.sv
// Concurrent checks on the ring loop carrier
`timescale 1ns/1ns
module rhb_assertions #(
  parameter logic [7:0] ADDR = 8'h00
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hb_a,
  input wire logic hb_b,
  input wire logic hb_ts,
  input wire logic [31:0] hb_time,
  input wire logic dev_hb_b,
  input wire logic relay_a_open,
  input wire logic relay_b_open,
  input wire logic st_vld,
  input wire logic [7:0] st_addr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // Cycles since the last beat and the last report
  logic [11:0] hb_cnt_r;
  logic [11:0] st_cnt_r;
  logic hb_seen_r;
  logic st_seen_r;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hb_cnt_r <= 12'h000;
      st_cnt_r <= 12'h000;
      hb_seen_r <= 1'b0;
      st_seen_r <= 1'b0;
    end
    else
    begin
      hb_cnt_r <= hb_a ? 12'h000 : hb_cnt_r + 12'h001;
      st_cnt_r <= st_vld ? 12'h000 : st_cnt_r + 12'h001;
      hb_seen_r <= hb_seen_r | hb_a;
      st_seen_r <= st_seen_r | st_vld;
    end
  end
  ////////////////////////////////////////////////////////////
  // Quiet tails after one-cycle pulses
  sequence hb_tail;
    !hb_a [*8];
  endsequence
  sequence st_tail;
    !st_vld [*8];
  endsequence
  ////////////////////////////////////////////////////////////
  // Heartbeat, time stamp, relays, reports
  hb_both_a: assert property (hb_a == hb_b)
    else $error("ports A and B beat apart");
  hb_pulse_a: assert property (hb_a |=> hb_tail)
    else $error("beat wider than one cycle");
  hb_period_a: assert property (hb_a && hb_seen_r |-> hb_cnt_r == 12'h3e7)
    else $error("beat period not 1000");
  ts_beat_a: assert property (hb_ts |-> hb_a)
    else $error("time stamp off a beat");
  time_hold_a: assert property (!hb_ts |-> $stable(hb_time))
    else $error("time word moved without stamp");
  relay_one_a: assert property (!(relay_a_open && relay_b_open))
    else $error("both relays open");
  relay_swap_a: assert property ($rose(relay_b_open) |-> $fell(relay_a_open))
    else $error("side B opened without swap");
  find_hold_a: assert property (relay_a_open && dev_hb_b |=> relay_a_open [*4])
    else $error("faulted side closed after find");
  st_frame_a: assert property (st_vld |-> st_addr == ADDR ##1 st_tail)
    else $error("bad report pulse or address");
  st_period_a: assert property (st_vld && st_seen_r |-> st_cnt_r == 12'h1f3)
    else $error("report period not 500");
endmodule

// ===== rhb_tb.sv
// Self-checking bench for supervisor and field node on one loop
`timescale 1ns/1ns
module rhb_tb;
  logic clock;
  logic sys_rst;
  logic psel, penable, pwrite, pready, pslverr, reset_btn, trouble, rdone, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, time_r, rtc;
  logic [3:0] fault_in, alarm_in;
  logic [5:0] fault_r;
  logic [4:0] alarm_r;
  logic [7:0] offline_r;
  logic local_fault, local_alarm, local_out, iso_active, iso_disabled, hb_ok;
  logic loop_ok, path_a, path_b, rd_seen, tstamp, ts_seen;
  int mismatches;
  int cmp_count;
  rhb_loop_if lp();
  ////////////////////////////////////////////////////////////
  // Ring model: beat returns on the far port, reaches node per path
  assign lp.rx_a = lp.hb_b & loop_ok;
  assign lp.rx_b = lp.hb_a & loop_ok;
  assign lp.dev_hb_a = lp.hb_a & path_a;
  assign lp.dev_hb_b = lp.hb_b & path_b;
  rhb_ctl #(.SEC_CYC(2000)) u_rhb_ctl (.clock(clock), .sys_rst(sys_rst), .lp(lp), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_in(fault_in), .alarm_in(alarm_in), .reset_btn(reset_btn),
    .rtc_time(rtc), .fault_r(fault_r), .alarm_r(alarm_r), .offline_r(offline_r),
    .trouble(trouble), .reset_done_r(rdone));
  rhb_dev #(.ADDR(8'h03), .TMO_CYC(20000)) u_rhb_dev (.clock(clock), .sys_rst(sys_rst), .lp(lp),
    .local_fault(local_fault), .local_alarm(local_alarm), .local_out_r(local_out), .iso_active(iso_active),
    .iso_disabled(iso_disabled), .hb_ok_r(hb_ok), .time_r(time_r), .time_stamp_r(tstamp));
  rhb_assertions #(.ADDR(8'h03)) u_rhb_assertions (.clock(clock), .sys_rst(sys_rst), .hb_a(lp.hb_a),
    .hb_b(lp.hb_b), .hb_ts(lp.hb_ts), .hb_time(lp.hb_time), .dev_hb_b(lp.dev_hb_b),
    .relay_a_open(lp.relay_a_open), .relay_b_open(lp.relay_b_open), .st_vld(lp.st_vld), .st_addr(lp.st_addr));
  ////////////////////////////////////////////////////////////
  // Clock and sticky event flags
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
    if (rdone === 1'b1) rd_seen <= 1'b1;
  always @(posedge clock)
    if (tstamp === 1'b1) ts_seen <= 1'b1;
  ////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    @(negedge clock);
    cmp_count++;
    if (g !== x)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    repeat (80000) @(posedge clock);
    mismatches++;
    $display("watchdog expired");
    close_out();
  end
  ////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    {psel, penable, pwrite, reset_btn, local_fault, local_alarm, rd_seen, ts_seen} = 8'h00;
    rtc = 32'h5a5a_0001;
    {paddr, pwdata, fault_in, alarm_in} = 48'h0;
    {loop_ok, path_a, path_b} = 3'b111;
    mismatches = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    cyc(4);
    sys_rst <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk("devcfg", 32'h0000_00ff, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    apb(1'b1, 8'h04, 32'h0000_0028);
    $display("test registers done");
    cyc(6000);
    chk("loop fault", 32'h0, 32'(fault_r));
    chk("offline", 32'h20, 32'(offline_r));
    apb(1'b0, 8'h0c, 32'h0);
    chk("offline reg", 32'h20, q);
    chk("node hears", 32'h1, 32'(hb_ok));
    chk("node time", 32'h5a5a_0001, time_r);
    chk("stamp seen", 32'h1, 32'(ts_seen));
    $display("test heartbeat done");
    cyc(1);
    {fault_in, alarm_in, local_fault, local_alarm} <= 10'h047;
    cyc(600);
    {fault_in, local_fault, local_alarm} <= 6'h00;
    apb(1'b1, 8'h04, 32'h0000_0008);
    cyc(600);
    reset_btn <= 1'b1;
    cyc(1);
    reset_btn <= 1'b0;
    cyc(3);
    chk("alarm kept", 32'h03, 32'(alarm_r));
    chk("refused", 32'h0, 32'(rd_seen));
    apb(1'b0, 8'h08, 32'h0);
    chk("flags", 32'h0003_0006, q);
    cyc(1);
    alarm_in <= 4'h0;
    cyc(4);
    apb(1'b1, 8'h00, 32'h1);
    cyc(3);
    chk("accepted", 32'h1, 32'(rd_seen));
    apb(1'b0, 8'h08, 32'h0);
    chk("flags clear", 32'h0, q);
    chk("offline clear", 32'h0, 32'(offline_r));
    $display("test latch done");
    loop_ok <= 1'b0;
    rtc <= 32'h5a5a_0002;
    cyc(3000);
    chk("break seen", 32'h1, 32'(fault_r[0]));
    chk("trouble", 32'h1, 32'(trouble));
    chk("time update", 32'h5a5a_0002, time_r);
    cyc(1);
    loop_ok <= 1'b1;
    cyc(3000);
    chk("break latched", 32'h1, 32'(fault_r[0]));
    cyc(1);
    reset_btn <= 1'b1;
    cyc(1);
    reset_btn <= 1'b0;
    cyc(3);
    chk("break reset", 32'h0, 32'(fault_r));
    $display("test continuity done");
    cyc(1);
    {path_a, path_b} <= 2'b00;
    cyc(4100);
    chk("search", 32'h1, 32'(iso_active));
    chk("open A", 32'h2, 32'({lp.relay_a_open, lp.relay_b_open}));
    cyc(1);
    path_b <= 1'b1;
    cyc(2000);
    chk("found", 32'h0, 32'(iso_active));
    chk("keep A", 32'h2, 32'({lp.relay_a_open, lp.relay_b_open}));
    cyc(1);
    {path_b, local_fault} <= 2'b01;
    cyc(4100);
    chk("restart A", 32'h2, 32'({lp.relay_a_open, lp.relay_b_open}));
    cyc(3000);
    chk("swap B", 32'h1, 32'({lp.relay_a_open, lp.relay_b_open}));
    chk("local runs", 32'h1, 32'(local_out));
    cyc(17500);
    chk("timed out", 32'h1, 32'(iso_disabled));
    chk("relays shut", 32'h0, 32'({lp.relay_a_open, lp.relay_b_open}));
    cyc(1);
    path_a <= 1'b1;
    cyc(1100);
    chk("re-enabled", 32'h0, 32'(iso_disabled));
    chk("hears again", 32'h1, 32'(hb_ok));
    $display("test isolation done");
    close_out();
  end
endmodule
